// File: logic/cmsl_cfg.svh
`ifndef CMSL_CFG_SVH
`define CMSL_CFG_SVH
// Notes on behaviour
// [R1] With no lock bit programmed, verify readout of code is permitted.
// [R2] Once any key byte is programmed, verify bytes are scrambled.
// [R3] Scrambled byte is stored byte XNOR a key byte; key never readable.
// [R4] First lock bit blocks external code table reads of internal code.
// [R5] First lock bit: access select sampled at reset and held.
// [R6] First lock bit refuses further programming of the code array.
// [R7] Both lock bits additionally disable verify mode entirely.
// [R8] Key array holds 64 bytes, all ones before programming.
// [R9] Only unprogrammed, first-only and both-bit states are defined.
// [R10] Second lock bit is only enabled together with the first.
// [R11] 8K image: code 0000-1FFF, key 2000-203F, lock bits at 2040.
// [R12] 16K image: code 0000-3FFF, key 4000-403F, lock bits at 4040.
// [R13] 32K image: code 0000-7FFF, key 8000-803F, lock bits at 8040.
// [R14] Image carries 64-byte key; key byte FF means no encryption.
// [R15] Lock bit value 0 enables the feature, 1 disables it.
// [R16] Pulse low 90 to 110 us, high at least 10 us between pulses.
// [R17] Five low pulses per code, key or lock byte write.
// [R18] Lock and key status decoded once at reset and then held.

// ****************************************
// Register map (Avalon word byte addresses)
// ****************************************
`define CMSL_OFS_STATUS 8'h00
`define CMSL_OFS_LOCK 8'h04
`define CMSL_OFS_KEY_ADDR 8'h08
`define CMSL_OFS_KEY_DATA 8'h0C
`define CMSL_OFS_VERIFY_ADDR 8'h10
`define CMSL_OFS_VERIFY_DATA 8'h14
`define CMSL_OFS_PROGRAM_PULSE 8'h18
`define CMSL_UNMAPPED_DATA 32'h0000_0000
// ****************************************
// Field positions and values
// ****************************************
`define CMSL_LOCK_FIRST_BIT 0
`define CMSL_LOCK_SECOND_BIT 1
`define CMSL_LOCK_RESET 2'h3
`define CMSL_KEY_BYTES 64
`define CMSL_KEY_ERASED 8'hFF
`define CMSL_BLANK_BYTE 8'hFF
// Image layouts, 8K/16K/32K
`define CMSL_KEY_BASE_8K 16'h2000
`define CMSL_LOCK_ADDR_8K 16'h2040
`define CMSL_KEY_BASE_16K 16'h4000
`define CMSL_LOCK_ADDR_16K 16'h4040
`define CMSL_KEY_BASE_32K 16'h8000
`define CMSL_LOCK_ADDR_32K 16'h8040
// ****************************************
// Timing
// ****************************************
`define CMSL_CLK_MHZ 125
`define CMSL_PULSE_MIN_US 90
`define CMSL_PULSE_MAX_US 110
`define CMSL_GAP_MIN_US 10
`define CMSL_PULSES_PER_BYTE 5
`define CMSL_PULSE_MIN_CYC (`CMSL_PULSE_MIN_US * `CMSL_CLK_MHZ)
`define CMSL_PULSE_MAX_CYC (`CMSL_PULSE_MAX_US * `CMSL_CLK_MHZ)
`define CMSL_GAP_MIN_CYC (`CMSL_GAP_MIN_US * `CMSL_CLK_MHZ)
`endif

// File: logic/cmsl_pkg.sv
`default_nettype none
package cmsl_pkg;
    typedef enum logic [1:0] {
        CMSL_SIZE_8K,
        CMSL_SIZE_16K,
        CMSL_SIZE_32K
    } cmsl_size_t;
    typedef enum logic [1:0] {
        CMSL_PROT_OPEN,
        CMSL_PROT_FIRST,
        CMSL_PROT_BOTH,
        CMSL_PROT_UNDEF
    } cmsl_prot_t;
endpackage
`default_nettype wire

// File: logic/cmsl_pulse_check.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmsl_cfg.svh"
// Qualifies programming pulses: low 90..110 us, high >= 10 us before.
module cmsl_pulse_check #(
    parameter int MIN_LOW = `CMSL_PULSE_MIN_CYC,
    parameter int MAX_LOW = `CMSL_PULSE_MAX_CYC,
    parameter int MIN_HIGH = `CMSL_GAP_MIN_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pulse pin, active low
    input wire logic pulse_n,
    // Results, one-cycle pulses
    output logic good,
    output logic bad
);
    logic [16:0] cnt_reg;
    logic gap_ok_reg;
    logic prev_reg;

    // Width counter restarts on each edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 17'h0_0000;
            prev_reg <= 1'b1;
            gap_ok_reg <= 1'b0;
            good <= 1'b0;
            bad <= 1'b0;
        end else begin
            prev_reg <= pulse_n;
            good <= 1'b0;
            bad <= 1'b0;
            if (pulse_n != prev_reg) begin
                cnt_reg <= 17'h0_0001;
                if (pulse_n) begin
                    // Rising edge closes a low pulse (see [R16])
                    if (gap_ok_reg && cnt_reg >= 17'(MIN_LOW) &&
                        cnt_reg <= 17'(MAX_LOW)) begin
                        good <= 1'b1;
                    end else begin
                        bad <= 1'b1;
                    end
                end else begin
                    gap_ok_reg <= (cnt_reg >= 17'(MIN_HIGH)); // see [R16]
                end
            end else if (cnt_reg != 17'h1_FFFF) begin
                cnt_reg <= cnt_reg + 17'h0_0001;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/cmsl_lock.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmsl_cfg.svh"
module cmsl_lock #(
    parameter int KEY_BYTES = `CMSL_KEY_BYTES,
    parameter int MIN_LOW = `CMSL_PULSE_MIN_CYC,
    parameter int MAX_LOW = `CMSL_PULSE_MAX_CYC,
    parameter int MIN_HIGH = `CMSL_GAP_MIN_CYC,
    parameter int PULSES = `CMSL_PULSES_PER_BYTE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Part size and pins
    input wire cmsl_pkg::cmsl_size_t part_size,
    input wire logic external_access_select,
    input wire logic program_pulse_n,
    // Code table read request from the core
    input wire logic code_table_read,
    input wire logic fetch_external,
    // Protection controls
    output logic code_table_read_allow,
    output logic external_access_held,
    output logic program_allow,
    output logic verify_allow,
    output logic scramble_on
);
    import cmsl_pkg::*;

    // ****************************************
    // State
    // ****************************************
    // Storage starts erased and is kept through reset, like the OTP cells
    logic [7:0] key_mem_reg [KEY_BYTES] =
        '{default: `CMSL_KEY_ERASED}; // see [R8]
    logic [1:0] lock_bits_byte_reg = `CMSL_LOCK_RESET;
    logic [5:0] key_addr_reg;
    logic [5:0] verify_addr_reg;
    logic [7:0] verify_data_reg;
    logic [7:0] program_pulse_data_reg;
    logic [1:0] program_pulse_target_reg;
    logic [2:0] pulse_cnt_reg;
    logic program_pulse_refused_reg;
    logic program_pulse_bad_reg;
    logic snap_done_reg;
    cmsl_prot_t prot_reg;
    logic ack_reg;
    logic pulse_good;
    logic pulse_bad;
    logic key_set;
    logic wr_hit;
    logic rd_hit;

    // Reads fetch in the wait cycle; writes land on the answer edge
    assign wr_hit = avs_write && ack_reg;
    assign rd_hit = avs_read && !ack_reg;

    // Any key byte off FF means encryption is on
    always_comb begin
        key_set = 1'b0;
        for (int i = 0; i < KEY_BYTES; i++) begin
            if (key_mem_reg[i] != `CMSL_KEY_ERASED) begin
                key_set = 1'b1; // see [R14]
            end
        end
    end

    // ****************************************
    // Programming pulse qualifier
    // ****************************************
    cmsl_pulse_check #(
        .MIN_LOW(MIN_LOW),
        .MAX_LOW(MAX_LOW),
        .MIN_HIGH(MIN_HIGH)
    ) u_pulse (
        .clk(clk),
        .rst_n(rst_n),
        .pulse_n(program_pulse_n),
        .good(pulse_good),
        .bad(pulse_bad)
    );

    // Bus acknowledge: waitrequest low on the second cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
        end
    end

    // Programming setup registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_addr_reg <= 6'h00;
            verify_addr_reg <= 6'h00;
            program_pulse_data_reg <= 8'hFF;
            program_pulse_target_reg <= 2'h0;
        end else if (wr_hit) begin
            case (avs_address)
                `CMSL_OFS_KEY_ADDR: key_addr_reg <= avs_writedata[5:0];
                `CMSL_OFS_VERIFY_ADDR: verify_addr_reg <= avs_writedata[5:0];
                `CMSL_OFS_PROGRAM_PULSE: begin
                    program_pulse_data_reg <= avs_writedata[7:0];
                    program_pulse_target_reg <= avs_writedata[9:8];
                end
                default: ;
            endcase
        end
    end

    // Five good pulses commit a byte; a bad one restarts the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt_reg <= 3'h0;
            program_pulse_bad_reg <= 1'b0;
        end else if (pulse_bad) begin
            // A bad pulse wins over a restart so it is never lost
            pulse_cnt_reg <= 3'h0;
            program_pulse_bad_reg <= 1'b1; // see [R16]
        end else if (wr_hit && avs_address == `CMSL_OFS_PROGRAM_PULSE) begin
            pulse_cnt_reg <= 3'h0;
            program_pulse_bad_reg <= 1'b0;
        end else if (pulse_good) begin
            if (pulse_cnt_reg == 3'(PULSES - 1)) begin
                pulse_cnt_reg <= 3'h0; // see [R17]
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg + 3'h1;
            end
        end
    end

    // Key array: OTP bits only go to zero; no reset, it must persist
    always_ff @(posedge clk) begin
        if (pulse_good && pulse_cnt_reg == 3'(PULSES - 1) &&
            program_pulse_target_reg == 2'h1 &&
            prot_reg == CMSL_PROT_OPEN) begin
            // Locked part refuses key writes (see [R6])
            key_mem_reg[key_addr_reg] <= key_mem_reg[key_addr_reg] &
                                         program_pulse_data_reg;
        end
    end

    // Lock bits: 0 enables, 1 disables; still writable when locked.
    // No reset: they are decoded at reset, so they must survive it
    always_ff @(posedge clk) begin
        if (pulse_good && pulse_cnt_reg == 3'(PULSES - 1) &&
            program_pulse_target_reg == 2'h2) begin
            lock_bits_byte_reg <= lock_bits_byte_reg &
                                  program_pulse_data_reg[1:0]; // see [R15]
        end
    end

    // Refused programming of code array is flagged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_pulse_refused_reg <= 1'b0;
        end else if (pulse_good && prot_reg != CMSL_PROT_OPEN &&
                     program_pulse_target_reg != 2'h2) begin
            // Set wins over a clear in the same cycle
            program_pulse_refused_reg <= 1'b1; // see [R6]
        end else if (wr_hit && avs_address == `CMSL_OFS_STATUS) begin
            program_pulse_refused_reg <= 1'b0;
        end
    end

    // ****************************************
    // Protection snapshot, taken once after reset release
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_done_reg <= 1'b0;
            prot_reg <= CMSL_PROT_OPEN;
            scramble_on <= 1'b0;
            external_access_held <= 1'b0;
        end else if (!snap_done_reg) begin
            snap_done_reg <= 1'b1; // see [R18]
            scramble_on <= key_set; // see [R2]
            external_access_held <= external_access_select; // see [R5]
            case (lock_bits_byte_reg)
                2'b11: prot_reg <= CMSL_PROT_OPEN; // see [R1]
                2'b10: prot_reg <= CMSL_PROT_FIRST;
                2'b00: prot_reg <= CMSL_PROT_BOTH; // see [R7]
                default: prot_reg <= CMSL_PROT_UNDEF; // see [R9] [R10]
            endcase
        end else if (prot_reg == CMSL_PROT_OPEN) begin
            // Unlocked parts follow the pin freely
            external_access_held <= external_access_select;
        end
    end

    // Derived controls, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_table_read_allow <= 1'b0;
            program_allow <= 1'b0;
            verify_allow <= 1'b0;
        end else begin
            // Undefined combination treated as fully locked, safe side
            code_table_read_allow <= snap_done_reg &&
                (prot_reg == CMSL_PROT_OPEN ||
                 !(code_table_read && fetch_external)); // see [R4]
            program_allow <= snap_done_reg &&
                             prot_reg == CMSL_PROT_OPEN; // see [R6]
            verify_allow <= snap_done_reg &&
                            (prot_reg == CMSL_PROT_OPEN ||
                             prot_reg == CMSL_PROT_FIRST); // see [R1] [R7]
        end
    end

    // Verify data: stored byte XNOR key byte; key itself never exposed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            verify_data_reg <= 8'h00;
        end else if (wr_hit && avs_address == `CMSL_OFS_VERIFY_DATA) begin
            if (!verify_allow) begin
                verify_data_reg <= 8'h00; // see [R7]
            end else if (scramble_on) begin
                verify_data_reg <= ~(avs_writedata[7:0] ^
                                     key_mem_reg[verify_addr_reg]); // see [R3]
            end else begin
                verify_data_reg <= avs_writedata[7:0]; // see [R1]
            end
        end
    end

    // Read mux
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            case (avs_address)
                `CMSL_OFS_STATUS: avs_readdata <= {22'h00_0000,
                    program_pulse_bad_reg, program_pulse_refused_reg, pulse_cnt_reg,
                    scramble_on, verify_allow, program_allow,
                    prot_reg};
                `CMSL_OFS_LOCK:
                    avs_readdata <= {30'h0000_0000, lock_bits_byte_reg};
                `CMSL_OFS_KEY_ADDR:
                    avs_readdata <= {26'h000_0000, key_addr_reg};
                `CMSL_OFS_VERIFY_ADDR:
                    avs_readdata <= {26'h000_0000, verify_addr_reg};
                `CMSL_OFS_VERIFY_DATA:
                    avs_readdata <= {24'h00_0000, verify_data_reg};
                `CMSL_OFS_PROGRAM_PULSE: avs_readdata <= {22'h00_0000,
                    program_pulse_target_reg, program_pulse_data_reg};
                default: avs_readdata <= `CMSL_UNMAPPED_DATA; // key hidden
            endcase
        end
    end

    // Part size only selects image layout off-chip (see [R11] [R12] [R13])
    logic unused_size;
    assign unused_size = ^part_size;
endmodule
`default_nettype wire

// File: verification/cmsl_lock_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cmsl_lock_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins and core request
    input wire logic external_access_select,
    input wire logic code_table_read,
    input wire logic fetch_external,
    // Protection controls
    input wire logic code_table_read_allow,
    input wire logic external_access_held,
    input wire logic program_allow,
    input wire logic verify_allow,
    input wire logic scramble_on
);
    logic [1:0] up_reg;
    logic settled;
    // Controls are only valid from the second edge after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_reg <= 2'h0;
        end else if (up_reg != 2'h3) begin
            up_reg <= up_reg + 2'h1;
        end
    end
    assign settled = (up_reg == 2'h3);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Properties
    // ****************************************
    chk_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> ##[0:1] !avs_waitrequest)
        else $error("waitrequest did not drop");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 8'h1C
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_table_open: assert property (
        settled && program_allow && code_table_read && fetch_external
        |=> code_table_read_allow)
        else $error("table read blocked on open part");
    chk_table_block: assert property (
        settled && !program_allow && code_table_read && fetch_external
        |=> !code_table_read_allow)
        else $error("table read allowed on locked part");
    chk_access_held: assert property (
        settled && !program_allow |=> $stable(external_access_held))
        else $error("access select not held");
    chk_access_follow: assert property (
        settled && program_allow
        |=> external_access_held == $past(external_access_select))
        else $error("access select not following pin");
    chk_verify_lock: assert property (
        settled && !verify_allow |-> !program_allow)
        else $error("verify off without first lock");
    chk_controls_hold: assert property (
        settled |=> $stable(program_allow) && $stable(verify_allow)
        && $stable(scramble_on))
        else $error("controls changed after reset");
endmodule
`default_nettype wire

// File: verification/cmsl_program_pulse_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmsl_program_pulse_model #(
    parameter int LOW = 10,
    parameter int HIGH = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control from the bench
    input wire logic start,
    input wire logic short_pulse,
    // Pin and status
    output logic program_pulse_n,
    output logic done
);
    int cyc_reg;
    int np_reg;
    logic busy_reg;
    // Five pulses; a high gap leads each one so every pulse is qualified unless short_pulse is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_pulse_n <= 1'b1;
            busy_reg <= 1'b0;
            done <= 1'b0;
            cyc_reg <= 0;
            np_reg <= 0;
        end else if (start && !busy_reg) begin
            busy_reg <= 1'b1;
            done <= 1'b0;
            cyc_reg <= 0;
            np_reg <= 0;
        end else if (busy_reg) begin
            cyc_reg <= cyc_reg + 1;
            if (program_pulse_n && cyc_reg == HIGH - 1) begin
                program_pulse_n <= 1'b0;
                cyc_reg <= 0;
            end else if (!program_pulse_n &&
                cyc_reg == (short_pulse ? 2 : LOW - 1)) begin
                program_pulse_n <= 1'b1;
                cyc_reg <= 0;
                np_reg <= np_reg + 1;
                busy_reg <= (np_reg != 4);
                done <= (np_reg == 4);
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/cmsl_lock_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmsl_cfg.svh"
module cmsl_lock_bench;
    import cmsl_pkg::*;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = ZERO;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic avs_waitrequest;
    logic ea_pin = 1'b0;
    logic code_table_read = 1'b0;
    logic fetch_external = 1'b0;
    logic pm_start = 1'b0;
    logic pm_short = 1'b0;
    logic pm_done, pulse_n, ctr_allow, ea_held, program_pulse_allow, ver_allow, scr_on;
    int errors = 0;
    int n_compared = 0;
    always #4 clk = ~clk;
    // Short pulse limits keep each byte write to a few dozen cycles
    cmsl_lock #(.MIN_LOW(9), .MAX_LOW(11), .MIN_HIGH(2)) dut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .part_size(CMSL_SIZE_8K),
        .external_access_select(ea_pin), .program_pulse_n(pulse_n),
        .code_table_read(code_table_read), .fetch_external(fetch_external),
        .code_table_read_allow(ctr_allow), .external_access_held(ea_held),
        .program_allow(program_pulse_allow), .verify_allow(ver_allow),
        .scramble_on(scr_on));
    cmsl_program_pulse_model #(.LOW(10), .HIGH(3)) u_program_pulse (
        .clk(clk), .rst_n(rst_n), .start(pm_start), .short_pulse(pm_short),
        .program_pulse_n(pulse_n), .done(pm_done));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp,
        input logic got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        // Look mid-cycle so the answer is seen settled, not in a race
        do begin
            @(negedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            errors++;
            wrap_up();
        end
        @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    // Stage a byte, then let the programmer pulse it in
    task automatic program_pulse(input logic [1:0] tgt, input logic [7:0] v,
        input logic short);
        int n;
        bus(1'b1, `CMSL_OFS_PROGRAM_PULSE, {22'h00_0000, tgt, v}, q);
        pm_short <= short;
        pm_start <= 1'b1;
        @(posedge clk);
        pm_start <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pm_done !== 1'b1 && n < 200);
        if (n >= 200) begin
            errors++;
            wrap_up();
        end
        // Last pulse is qualified and committed two edges after it ends
        repeat (4) @(posedge clk);
    endtask
    task automatic vfy(input logic [7:0] stored);
        bus(1'b1, `CMSL_OFS_VERIFY_ADDR, ZERO, q);
        bus(1'b1, `CMSL_OFS_VERIFY_DATA, {24'h00_0000, stored}, q);
        bus(1'b0, `CMSL_OFS_VERIFY_DATA, ZERO, q);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_open();
        check_bit("no key", 1'b0, scr_on);
        bus(1'b0, `CMSL_OFS_STATUS, ZERO, q);
        check("status", 32'h0000_000C, q);
        bus(1'b0, `CMSL_OFS_LOCK, ZERO, q);
        check("lock bits", 32'h0000_0003, q);
        code_table_read <= 1'b1;
        fetch_external <= 1'b1;
        ea_pin <= 1'b1;
        repeat (3) @(posedge clk);
        check_bit("table read", 1'b1, ctr_allow);
        check_bit("access follows", 1'b1, ea_held);
        vfy(8'h3C);
        check("plain verify", 32'h0000_003C, q);
        bus(1'b0, 8'h1C, ZERO, q);
        check("unmapped", `CMSL_UNMAPPED_DATA, q);
    endtask
    // Image layout the programmer follows for each part size
    task automatic t_image();
        check("key 8K", 32'h0000_2000, 32'(`CMSL_KEY_BASE_8K));
        check("lock 8K", 32'h0000_2040, 32'(`CMSL_LOCK_ADDR_8K));
        check("key 16K", 32'h0000_4000, 32'(`CMSL_KEY_BASE_16K));
        check("lock 16K", 32'h0000_4040, 32'(`CMSL_LOCK_ADDR_16K));
        check("key 32K", 32'h0000_8000, 32'(`CMSL_KEY_BASE_32K));
        check("lock 32K", 32'h0000_8040, 32'(`CMSL_LOCK_ADDR_32K));
    endtask
    // Out-of-range pulses are flagged and commit nothing
    task automatic t_bad();
        program_pulse(2'h0, 8'h11, 1'b1);
        bus(1'b0, `CMSL_OFS_STATUS, ZERO, q);
        check_bit("bad pulse", 1'b1, q[9]);
    endtask
    task automatic t_key();
        bus(1'b1, `CMSL_OFS_KEY_ADDR, ZERO, q);
        program_pulse(2'h1, 8'h5A, 1'b0);
        do_reset();
        check_bit("scramble", 1'b1, scr_on);
        vfy(8'h3C);
        check("xnor verify", 32'h0000_0099, q);
        bus(1'b0, `CMSL_OFS_KEY_DATA, ZERO, q);
        check("key hidden", `CMSL_UNMAPPED_DATA, q);
    endtask
    // Pin is captured at reset, then moved to prove it is ignored
    task automatic t_lock1();
        program_pulse(2'h2, 8'hFE, 1'b0);
        ea_pin <= 1'b1;
        do_reset();
        ea_pin <= 1'b0;
        repeat (3) @(posedge clk);
        check_bit("access held", 1'b1, ea_held);
        check_bit("table read", 1'b0, ctr_allow);
        check_bit("program", 1'b0, program_pulse_allow);
        check_bit("verify", 1'b1, ver_allow);
        program_pulse(2'h0, 8'h00, 1'b0);
        bus(1'b0, `CMSL_OFS_STATUS, ZERO, q);
        check_bit("refused", 1'b1, q[8]);
    endtask
    task automatic t_lock2();
        program_pulse(2'h2, 8'hFE, 1'b0);
        program_pulse(2'h2, 8'hFC, 1'b0);
        do_reset();
        check_bit("verify", 1'b0, ver_allow);
        vfy(8'h3C);
        check("locked verify", ZERO, q);
    endtask
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_open();
        t_image();
        t_bad();
        t_key();
        t_lock1();
        t_lock2();
        wrap_up();
    end
    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule
bind cmsl_lock cmsl_lock_chk u_chk (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_access_select(external_access_select),
    .code_table_read(code_table_read), .fetch_external(fetch_external),
    .code_table_read_allow(code_table_read_allow),
    .external_access_held(external_access_held),
    .program_allow(program_allow), .verify_allow(verify_allow),
    .scramble_on(scramble_on));
`default_nettype wire
